// [core/lmx_scan_core.sv]
// LED matrix scan sequencer and current gain settings, APB slave
`timescale 1ns/1ps
`include "lmx_regs.svh"
module lmx_scan_core #(
    parameter int LINES = 11,
    parameter int SINKS = 18
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output wire logic [31:0]      prdata,
    output wire logic             pready,
    output wire logic             pslverr,
    output wire logic [LINES-1:0] scan_line_on,
    output wire logic [SINKS-1:0] current_sink_output,
    output wire logic             scan_discharge,
    output wire logic             sink_precharge,
    output wire logic [1:0]       precharge_level,
    output wire logic [2:0]       peak_current_code,
    output wire logic [SINKS*7-1:0] sink_color_gain,
    output wire logic [SINKS*8-1:0] sink_dot_gain,
    output wire logic [SINKS*2-1:0] sink_comp,
    output lmx_pkg::lmx_line_t    line_index
);
    import lmx_pkg::*;

    // Dot index must fit the 8-bit address register
    if (LINES < 6 || LINES > 15 || SINKS % 3 != 0
        || LINES * SINKS > 256) begin : g_bad
        $error("lmx_scan_core: unsupported LINES or SINKS");
    end

    localparam int DOTS = LINES * SINKS;

    function automatic lmx_line_t lmx_clamp(input logic [3:0] v);
        if (v < 4'h6) begin
            return 4'h6;
        end else if (v > 4'(LINES)) begin
            return 4'(LINES);
        end
        return v;
    endfunction

    function automatic logic [7:0] lmx_dot_idx(input lmx_line_t l,
                                               input int s);
        return 8'(int'(l) * SINKS + s);
    endfunction

    // Bus state
    logic        pready_reg;
    logic        pslverr_reg;
    logic [31:0] prdata_reg;
    // Software settings
    logic        chip_en_reg;
    logic        chip_prev_reg;
    logic [3:0]  lines_reg;
    logic        pwm_slow_reg;
    logic [1:0]  mode_reg;
    logic        blk_half_reg;
    logic        stagger_reg;
    logic        delay_en_reg;
    logic [5:0]  comp_reg;
    logic [6:0]  color_reg [3];
    logic [7:0]  daddr_reg;
    logic [7:0]  dot_mem [DOTS];
    // Scan state
    lmx_state_e  state_reg;
    lmx_state_e  state_next;
    lmx_line_t   line_reg;
    lmx_cnt_t    cnt_reg;
    lmx_cnt_t    t_pwm;
    lmx_cnt_t    t_blk;
    lmx_cnt_t    t_ph;
    lmx_cnt_t    t_sft;
    logic        line_end;
    logic [2:0]  peak_pend;
    logic [2:0]  peak_act;
    logic [2:0]  cfg3_pend;
    logic [2:0]  cfg3_act;
    logic [2:0]  grp_on;
    // Registered outputs
    logic [LINES-1:0]   scan_reg;
    logic [SINKS-1:0]   sink_reg;
    logic               disch_reg;
    logic               prech_reg;
    logic               blank_reg;
    logic [SINKS*7-1:0] color_out_reg;
    logic [SINKS*8-1:0] dot_out_reg;
    logic [SINKS*2-1:0] comp_out_reg;

    // APB decode; one wait state so read data comes from a flop
    wire acc    = psel & penable;
    wire take   = acc & ~pready_reg;
    wire hit    = (paddr[1:0] == 2'h0) && (paddr <= `LMX_A_STAT);
    wire wr_en  = acc & pready_reg & pwrite & hit;
    wire wr_chip  = wr_en && (paddr == `LMX_A_CHIP);
    wire wr_init  = wr_en && (paddr == `LMX_A_INIT);
    wire wr_cfg1  = wr_en && (paddr == `LMX_A_CFG1);
    wire wr_cfg2  = wr_en && (paddr == `LMX_A_CFG2);
    wire wr_cfg3  = wr_en && (paddr == `LMX_A_CFG3);
    wire wr_peak  = wr_en && (paddr == `LMX_A_PEAK);
    wire wr_color = wr_en && (paddr == `LMX_A_COLOR);
    wire wr_daddr = wr_en && (paddr == `LMX_A_DADDR);
    wire wr_ddata = wr_en && (paddr == `LMX_A_DDATA);
    wire dvalid   = daddr_reg < 8'(DOTS);

    // Mode 0 is not defined; it behaves as immediate update
    wire mode_imm  = (mode_reg == 2'h1) || (mode_reg == 2'h0);
    wire chip_rise = chip_en_reg & ~chip_prev_reg;
    wire run       = (state_reg == LMX_RUN);
    wire blank     = cnt_reg < t_blk;
    lmx_line_t n_lines;
    assign n_lines = lmx_clamp(lines_reg);
    wire wrap = line_reg >= n_lines - 4'h1;
    wire [9:0] dly = delay_en_reg ? t_sft : 10'h0;

    // Read data selection
    wire [31:0] rd_color = {9'h0, color_reg[2], 1'b0, color_reg[1],
                            1'b0, color_reg[0]};
    wire [31:0] rd_stat  = {18'h0, cfg3_act, peak_act, 2'h0,
                            blank, run, line_reg};
    wire [31:0] rd_data =
        (paddr == `LMX_A_CHIP)  ? {31'h0, chip_en_reg} :
        (paddr == `LMX_A_INIT)  ? {25'h0, mode_reg, pwm_slow_reg,
                                   lines_reg} :
        (paddr == `LMX_A_CFG1)  ? {29'h0, delay_en_reg, stagger_reg,
                                   blk_half_reg} :
        (paddr == `LMX_A_CFG2)  ? {26'h0, comp_reg} :
        (paddr == `LMX_A_CFG3)  ? {29'h0, cfg3_pend} :
        (paddr == `LMX_A_PEAK)  ? {29'h0, peak_pend} :
        (paddr == `LMX_A_COLOR) ? rd_color :
        (paddr == `LMX_A_DADDR) ? {24'h0, daddr_reg} :
        (paddr == `LMX_A_DDATA) ? {24'h0, dvalid ? dot_mem[daddr_reg]
                                                 : 8'h0} :
        (paddr == `LMX_A_STAT)  ? rd_stat : 32'h0;

    // Bus answer flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0;
        end else begin
            pready_reg  <= take;
            pslverr_reg <= take & ~hit;
            if (take) begin
                prdata_reg <= (hit && !pwrite) ? rd_data : 32'h0;
            end
        end
    end

    // Plain configuration registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            chip_en_reg   <= 1'b0;
            chip_prev_reg <= 1'b0;
            lines_reg     <= `LMX_LINES_RST;
            pwm_slow_reg  <= 1'b0;
            mode_reg      <= `LMX_MODE_RST;
            blk_half_reg  <= 1'b0;
            stagger_reg   <= 1'b0;
            delay_en_reg  <= 1'b0;
            comp_reg      <= 6'h0;
            daddr_reg     <= 8'h0;
        end else begin
            chip_prev_reg <= chip_en_reg;
            if (wr_chip) begin
                chip_en_reg <= pwdata[0];
            end
            if (wr_init) begin
                lines_reg    <= pwdata[3:0];
                pwm_slow_reg <= pwdata[`LMX_INIT_PWM];
                mode_reg     <= pwdata[`LMX_INIT_MODE +: 2];
            end
            if (wr_cfg1) begin
                blk_half_reg <= pwdata[`LMX_CFG1_BLK];
                stagger_reg  <= pwdata[`LMX_CFG1_STAG];
                delay_en_reg <= pwdata[`LMX_CFG1_DLY];
            end
            if (wr_cfg2) begin
                comp_reg <= pwdata[5:0];
            end
            if (wr_daddr) begin
                daddr_reg <= pwdata[7:0];
            end
        end
    end

    // Color gains, one word for all three groups
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int g = 0; g < 3; g++) begin
                color_reg[g] <= `LMX_COLOR_RST;
            end
        end else if (wr_color) begin
            color_reg[0] <= pwdata[6:0];
            color_reg[1] <= pwdata[`LMX_COLOR_TWO +: 7];
            color_reg[2] <= pwdata[`LMX_COLOR_THREE +: 7];
        end
    end

    // Dot gain store; writes past the last dot are dropped
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int d = 0; d < DOTS; d++) begin
                dot_mem[d] <= `LMX_DOT_RST;
            end
        end else if (wr_ddata && dvalid) begin
            dot_mem[daddr_reg] <= pwdata[7:0];
        end
    end

    // Peak code and deghost settings share the deferred update
    lmx_defer_hold #(
        .W   (3),
        .RST (`LMX_PEAK_RST)
    ) u_peak (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .imm       (mode_imm),
        .chip_en   (chip_en_reg),
        .chip_rise (chip_rise),
        .wr        (wr_peak),
        .wdata     (pwdata[2:0]),
        .pend_reg  (peak_pend),
        .act_reg   (peak_act)
    );

    lmx_defer_hold #(
        .W   (3),
        .RST (`LMX_CFG3_RST)
    ) u_cfg3 (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .imm       (mode_imm),
        .chip_en   (chip_en_reg),
        .chip_rise (chip_rise),
        .wr        (wr_cfg3),
        .wdata     (pwdata[2:0]),
        .pend_reg  (cfg3_pend),
        .act_reg   (cfg3_act)
    );

    // Scan runs while the chip is enabled
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            LMX_IDLE: if (chip_en_reg) state_next = LMX_RUN;
            LMX_RUN:  if (!chip_en_reg) state_next = LMX_IDLE;
            default:  state_next = LMX_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= LMX_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    lmx_line_timer u_timer (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .run      (run),
        .pwm_slow (pwm_slow_reg),
        .blk_half (blk_half_reg),
        .stagger  (stagger_reg),
        .cnt_reg  (cnt_reg),
        .t_pwm    (t_pwm),
        .t_blk    (t_blk),
        .t_ph     (t_ph),
        .t_sft    (t_sft),
        .line_end (line_end)
    );

    // Line stepping; wrap also catches a count lowered mid-scan
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            line_reg <= 4'h0;
        end else if (!run) begin
            line_reg <= 4'h0;
        end else if (line_end) begin
            line_reg <= wrap ? 4'h0 : line_reg + 4'h1;
        end
    end

    // Phase groups open one phase time apart, each for the active time less any enabled delay
    for (genvar g = 0; g < 3; g++) begin : g_grp
        wire [9:0] start = t_blk + dly + 10'(g) * t_ph;
        wire [9:0] stop  = t_blk + 10'(g) * t_ph + t_pwm;
        assign grp_on[g] = run && (cnt_reg >= start)
                           && (cnt_reg < stop);
    end

    // Line and sink drive; the line is released during blank
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            scan_reg  <= '0;
            sink_reg  <= '0;
            disch_reg <= 1'b0;
            prech_reg <= 1'b0;
            blank_reg <= 1'b0;
        end else begin
            scan_reg  <= (run && !blank) ? LINES'(1) << line_reg
                                         : '0;
            for (int i = 0; i < SINKS; i++) begin
                sink_reg[i] <= grp_on[i % 3];
            end
            disch_reg <= run && blank && cfg3_act[0];
            prech_reg <= run && blank;
            blank_reg <= run && blank;
        end
    end

    // Per-sink gains from group and dot settings
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            color_out_reg <= {SINKS{`LMX_COLOR_RST}};
            dot_out_reg   <= {SINKS{`LMX_DOT_RST}};
            comp_out_reg  <= '0;
        end else begin
            for (int i = 0; i < SINKS; i++) begin
                color_out_reg[i*7 +: 7] <= color_reg[i % 3];
                dot_out_reg[i*8 +: 8] <=
                    dot_mem[lmx_dot_idx(line_reg, i)];
                comp_out_reg[i*2 +: 2] <= comp_reg[(i % 3)*2 +: 2];
            end
        end
    end

    assign prdata              = prdata_reg;
    assign pready              = pready_reg;
    assign pslverr             = pslverr_reg;
    assign scan_line_on        = scan_reg;
    assign current_sink_output = sink_reg;
    assign scan_discharge      = disch_reg;
    assign sink_precharge      = prech_reg;
    assign precharge_level     = cfg3_act[2:1];
    assign peak_current_code   = peak_act;
    assign sink_color_gain     = color_out_reg;
    assign sink_dot_gain       = dot_out_reg;
    assign sink_comp           = comp_out_reg;
    assign line_index          = line_reg;

    // Checking helpers: independent line period count
    logic [9:0] per_cnt_reg;
    logic       seen_reg;
    // Expected length decoded from the settings, not from the timer
    wire  [9:0] per_exp =
        (pwm_slow_reg ? 10'(`LMX_CYC(`LMX_T_PWM_SLOW_PS))
                      : 10'(`LMX_CYC(`LMX_T_PWM_FAST_PS)))
        + (blk_half_reg ? 10'(`LMX_CYC(`LMX_T_BLK_SHORT_PS))
                        : 10'(`LMX_CYC(`LMX_T_BLK_LONG_PS)))
        + (stagger_reg ? 10'(2 * `LMX_CYC(`LMX_T_PHASE_PS)) : 10'h0);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            per_cnt_reg <= 10'h0;
            seen_reg    <= 1'b0;
        end else if (!run || line_end) begin
            per_cnt_reg <= 10'h0;
            seen_reg    <= run;
        end else begin
            per_cnt_reg <= per_cnt_reg + 10'h1;
        end
    end

    sequence lmx_enable_s;
        $rose(chip_en_reg);
    endsequence
    sequence lmx_running_s;
        ##[1:2] run;
    endsequence

    line_wrap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        line_end && wrap |=> line_reg == 4'h0)
        else $error("scan did not restart at line 0");
    line_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        run && line_end && !wrap |=> line_reg == $past(line_reg) + 4'h1)
        else $error("scan line did not advance by one");
    line_limit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        run && $stable(lines_reg) |-> line_reg < n_lines)
        else $error("scan line beyond active count");
    period_len_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        line_end && seen_reg && $stable(per_exp)
        |-> per_cnt_reg == per_exp - 10'h1)
        else $error("line period length wrong");
    blank_dark_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        run && blank |=> current_sink_output == '0 && scan_line_on == '0)
        else $error("drive active during blank");
    one_line_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $onehot0(scan_line_on))
        else $error("more than one scan line on");
    peak_imm_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_peak && mode_imm |=> peak_act == $past(pwdata[2:0]))
        else $error("immediate peak code not applied");
    peak_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !mode_imm && chip_en_reg && chip_prev_reg && $stable(mode_reg)
        |=> $stable(peak_act))
        else $error("peak code changed while enabled");
    discharge_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        run && blank && cfg3_act[0] |=> scan_discharge)
        else $error("no discharge during blank");
    wake_run_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        lmx_enable_s |-> lmx_running_s)
        else $error("scan did not start after enable");
endmodule // lmx_scan_core

// [core/lmx_regs.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef LMX_REGS_SVH
`define LMX_REGS_SVH
`define LMX_A_CHIP      8'h00
`define LMX_A_INIT      8'h04
`define LMX_A_CFG1      8'h08
`define LMX_A_CFG2      8'h0C
`define LMX_A_CFG3      8'h10
`define LMX_A_PEAK      8'h14
`define LMX_A_COLOR     8'h18
`define LMX_A_DADDR     8'h1C
`define LMX_A_DDATA     8'h20
`define LMX_A_STAT      8'h24
`define LMX_INIT_PWM    4
`define LMX_INIT_MODE   5
`define LMX_CFG1_BLK    0
`define LMX_CFG1_STAG   1
`define LMX_CFG1_DLY    2
`define LMX_COLOR_TWO   8
`define LMX_COLOR_THREE 16
`define LMX_LINES_RST   4'hB
`define LMX_MODE_RST    2'h1
`define LMX_PEAK_RST    3'h3
`define LMX_COLOR_RST   7'h40
`define LMX_DOT_RST     8'h80
`define LMX_CFG3_RST    3'h0
`define LMX_CLK_PS      40000
`define LMX_T_PWM_FAST_PS  8000000
`define LMX_T_PWM_SLOW_PS  16000000
`define LMX_T_BLK_LONG_PS  1000000
`define LMX_T_BLK_SHORT_PS 500000
`define LMX_T_PHASE_PS     125000
`define LMX_T_SFT_SLOW_PS  62500
`define LMX_T_SFT_FAST_PS  31250
`define LMX_CYC(t) (((t) + `LMX_CLK_PS - 1) / `LMX_CLK_PS)
`endif

// [core/lmx_pkg.sv]
// Types shared by the scan and gain logic
package lmx_pkg;
    typedef enum logic [1:0] {
        LMX_IDLE = 2'b01,
        LMX_RUN  = 2'b10
    } lmx_state_e;
    typedef logic [3:0] lmx_line_t;
    typedef logic [9:0] lmx_cnt_t;
endpackage

// [core/lmx_line_timer.sv]
// Line period counter with selectable active, blank and phase times
`timescale 1ns/1ps
`include "lmx_regs.svh"
module lmx_line_timer (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             run,
    input  wire logic             pwm_slow,
    input  wire logic             blk_half,
    input  wire logic             stagger,
    output lmx_pkg::lmx_cnt_t     cnt_reg,
    output lmx_pkg::lmx_cnt_t     t_pwm,
    output lmx_pkg::lmx_cnt_t     t_blk,
    output lmx_pkg::lmx_cnt_t     t_ph,
    output lmx_pkg::lmx_cnt_t     t_sft,
    output wire logic             line_end
);
    import lmx_pkg::*;
    lmx_cnt_t period;

    // Times rounded up to whole cycles
    assign t_pwm = pwm_slow ? 10'(`LMX_CYC(`LMX_T_PWM_SLOW_PS))
                            : 10'(`LMX_CYC(`LMX_T_PWM_FAST_PS));
    assign t_blk = blk_half ? 10'(`LMX_CYC(`LMX_T_BLK_SHORT_PS))
                            : 10'(`LMX_CYC(`LMX_T_BLK_LONG_PS));
    assign t_ph  = stagger ? 10'(`LMX_CYC(`LMX_T_PHASE_PS)) : 10'h0;
    assign t_sft = pwm_slow ? 10'(`LMX_CYC(`LMX_T_SFT_SLOW_PS))
                            : 10'(`LMX_CYC(`LMX_T_SFT_FAST_PS));
    assign period = t_pwm + t_blk + t_ph + t_ph;
    assign line_end = run && (cnt_reg == period - 10'h1);

    // Counter restarts with each line; held at zero while stopped
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 10'h0;
        end else if (!run || line_end) begin
            cnt_reg <= 10'h0;
        end else begin
            cnt_reg <= cnt_reg + 10'h1;
        end
    end
endmodule // lmx_line_timer

// [core/lmx_defer_hold.sv]
// Setting with immediate or chip-enable-deferred update
`timescale 1ns/1ps
module lmx_defer_hold #(
    parameter int           W   = 3,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic         imm,
    input  wire logic         chip_en,
    input  wire logic         chip_rise,
    input  wire logic         wr,
    input  wire logic [W-1:0] wdata,
    output logic      [W-1:0] pend_reg,
    output logic      [W-1:0] act_reg
);
    import lmx_pkg::*;
    if (W < 1) begin : g_bad
        $error("lmx_defer_hold: W must be positive");
    end

    // Writes while enabled in framed modes are dropped, not queued
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pend_reg <= RST;
            act_reg  <= RST;
        end else begin
            if (wr && (imm || !chip_en)) begin
                pend_reg <= wdata;
            end
            if (imm && wr) begin
                act_reg <= wdata;
            end else if (!imm && chip_rise) begin
                act_reg <= pend_reg;
            end
        end
    end
endmodule // lmx_defer_hold

// [verif/lmx_led_matrix.sv]
// LED matrix model seen through the scan lines and current sinks
`timescale 1ns/1ps
module lmx_led_matrix (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [10:0] scan_line_on,
    input  wire logic [17:0] current_sink_output,
    input  wire logic        scan_discharge,
    input  wire logic        sink_precharge,
    output int               n_bad,
    output int               n_dis
);
    // Two rows on at once short the matrix; sinks lit in blank ghost
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            n_bad <= 0;
            n_dis <= 0;
        end else begin
            if ($countones(scan_line_on) > 1 ||
                (sink_precharge && current_sink_output != 18'h0))
                n_bad <= n_bad + 1;
            if (scan_discharge && sink_precharge && scan_line_on == 11'h0)
                n_dis <= n_dis + 1;
        end
    end
endmodule // lmx_led_matrix

// [verif/led_matrix_scan_and_current_gain_bench.sv]
// Self-checking bench for the LED matrix scan and gain block
`timescale 1ns/1ps
`include "lmx_regs.svh"
module led_matrix_scan_and_current_gain_bench;
    import lmx_pkg::*;
    logic         clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
    logic         scan_discharge, sink_precharge, err;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata, rd, v;
    logic [10:0]  scan_line_on;
    logic [17:0]  current_sink_output;
    logic [1:0]   precharge_level, lv;
    logic [2:0]   peak_current_code, pk, q;
    logic [125:0] sink_color_gain;
    logic [143:0] sink_dot_gain;
    logic [35:0]  sink_comp;
    lmx_line_t    line_index;
    int           n_fail, comparisons, n_bad, n_dis, seed, n, nl, ex, tot;

    lmx_scan_core #(.LINES(11), .SINKS(18)) lmx_scan_core_i (
        .clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .scan_line_on, .current_sink_output,
        .scan_discharge, .sink_precharge, .precharge_level,
        .peak_current_code, .sink_color_gain, .sink_dot_gain, .sink_comp,
        .line_index);
    lmx_led_matrix lmx_led_matrix_i (
        .clk_sys, .rst_n, .scan_line_on, .current_sink_output,
        .scan_discharge, .sink_precharge, .n_bad, .n_dis);

    // Expected line period in clocks: active plus blank plus two phase times
    function automatic int period(logic s, logic h, logic g);
        return (s ? `LMX_CYC(`LMX_T_PWM_SLOW_PS) : `LMX_CYC(`LMX_T_PWM_FAST_PS))
            + (h ? `LMX_CYC(`LMX_T_BLK_SHORT_PS) : `LMX_CYC(`LMX_T_BLK_LONG_PS))
            + (g ? 2 * `LMX_CYC(`LMX_T_PHASE_PS) : 0);
    endfunction

    task automatic chk(input logic [143:0] got, input logic [143:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; pready read before the edge's updates land
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Write, then let the registered outputs follow
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // Wait for the onset of scan line k, counting clocks
    task automatic wline(input int k);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (scan_line_on !== 11'(1) << k && n < 3000);
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // Hang guard, well above the longest scan sweep
    initial begin
        #(40 * 60000);
        n_fail++;
        give_verdict();
    end

    initial begin
        seed = 32'h989ef2fe;
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        lv = 2'h0;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        chk(peak_current_code, 3'h3);
        chk(sink_color_gain, {18{7'h40}});
        chk(sink_dot_gain, {18{8'h80}});
        rchk(`LMX_A_PEAK, 32'h3);
        rchk(`LMX_A_COLOR, 32'h00404040);
        rchk(`LMX_A_INIT, 32'h2B);
        apb(1'b0, 8'h28, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, 8'h06, 32'h0);
        chk(err, 1'b1);
        // Random gains, compensation and immediate peak codes
        repeat (4) begin
            v = $random(seed);
            wr(`LMX_A_COLOR, v);
            wr(`LMX_A_CFG2, v);
            for (int i = 0; i < 18; i++) begin
                chk(sink_color_gain[i*7+:7], v[(i%3)*8+:7]);
                chk(sink_comp[i*2+:2], v[(i%3)*2+:2]);
            end
            pk = 3'(($random(seed) & 32'h7FFF) % 7);
            wr(`LMX_A_PEAK, pk);
            chk(peak_current_code, pk);
        end
        // Small current: peak code lowered before the gains
        wr(`LMX_A_PEAK, 32'h0);
        wr(`LMX_A_COLOR, 32'h00010101);
        chk(peak_current_code, 3'h0);
        chk(sink_color_gain[20:0], {3{7'h01}});
        pk = 3'h0;
        // Frame modes: peak and cfg3 held until chip enable rises
        for (int m = 2; m < 4; m++) begin
            q = 3'((pk + 1) % 7);
            wr(`LMX_A_INIT, 32'h0B | (m << 5));
            wr(`LMX_A_CHIP, 32'h1);
            wr(`LMX_A_PEAK, q);
            chk(peak_current_code, pk);
            wr(`LMX_A_CHIP, 32'h0);
            wr(`LMX_A_PEAK, q);
            wr(`LMX_A_CFG3, {q[1:0], 1'b1});
            chk(peak_current_code, pk);
            chk(precharge_level, lv);
            wr(`LMX_A_CHIP, 32'h1);
            chk(peak_current_code, q);
            chk(precharge_level, q[1:0]);
            pk = q;
            lv = q[1:0];
        end
        // Scan order, clamped line count and line period
        for (int c = 0; c < 3; c++) begin
            nl = c == 0 ? 4 : c == 1 ? 15 : 6 + ($random(seed) & 32'h7FFF) % 6;
            ex = nl < 6 ? 6 : nl > 11 ? 11 : nl;
            wr(`LMX_A_CHIP, 32'h0);
            wr(`LMX_A_INIT, nl | 32'h20 | (c[0] ? 32'h10 : 32'h0));
            wr(`LMX_A_CFG1, (c[0] ? 32'h0 : 32'h1) | (c[1] ? 32'h6 : 32'h0));
            wr(`LMX_A_CHIP, 32'h1);
            wline(0);
            tot = 0;
            for (int k = 1; k <= ex; k++) begin
                wline(k % ex);
                chk(line_index, k % ex);
                chk(current_sink_output[0], !c[1]);
                tot += n;
                chk(n, period(c[0], !c[0], c[1]));
            end
            chk(tot, ex * period(c[0], !c[0], c[1]));
        end
        // Dot gain store, and an index past the last dot
        wr(`LMX_A_DADDR, 32'd5);
        v = $random(seed);
        wr(`LMX_A_DDATA, v);
        rchk(`LMX_A_DDATA, {24'h0, v[7:0]});
        wr(`LMX_A_DADDR, 32'd198);
        wr(`LMX_A_DDATA, v);
        rchk(`LMX_A_DDATA, 32'h0);
        wline(0);
        chk(sink_dot_gain[47:40], v[7:0]);
        chk(n_bad, 0);
        chk(n_dis > 0, 1'b1);
        give_verdict();
    end
endmodule // led_matrix_scan_and_current_gain_bench
